/* File: rtl/ect_pkg.sv */
// Shared constants and types of the embedded capture and trigger core.
package ect_pkg;

	// ------------------------------------------------------------
	// Widths and depth
	// ------------------------------------------------------------
	localparam int PW = 16;
	localparam int AW = 17;
	localparam int CW = 18;
	localparam logic [CW-1:0] DEPTH_MAX = 18'h20000;
	localparam int MEM_WORDS = 131072;
	localparam int MEM_BLOCK = 0;
	localparam int MEM_LUT = 1;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_DEPTH = 8'h04;
	localparam logic [7:0] A_TRGEN = 8'h08;
	localparam logic [7:0] A_STREN = 8'h0c;
	localparam logic [7:0] A_DBGEN = 8'h10;
	localparam logic [7:0] A_COND = 8'h14;
	localparam logic [7:0] A_BUSPAT = 8'h18;
	localparam logic [7:0] A_ADV = 8'h1c;
	localparam logic [7:0] A_STATUS = 8'h20;
	localparam logic [7:0] A_TRIGADDR = 8'h24;
	localparam logic [7:0] A_RDADDR = 8'h28;
	localparam logic [7:0] A_RDDATA = 8'h2c;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int B_ARM = 0;
	localparam int B_STOP = 1;
	localparam int B_SEG = 2;
	localparam int B_CONT = 3;
	localparam int B_ADV = 4;
	localparam int B_TPOS = 5;
	localparam int B_SEGL = 8;
	localparam int B_DBG = 11;
	localparam int B_ADV_SRC = 2;
	localparam int B_ADV_AND = 3;
	localparam int B_ADV_K = 8;

	// ------------------------------------------------------------
	// Reset values and codes
	// ------------------------------------------------------------
	localparam logic [CW-1:0] DEPTH_RST = 18'h00400;
	localparam logic [PW-1:0] EN_RST = 16'hffff;
	localparam logic [2:0] C_DC = 3'h0;
	localparam logic [2:0] C_LOW = 3'h1;
	localparam logic [2:0] C_HIGH = 3'h2;
	localparam logic [2:0] C_FALL = 3'h3;
	localparam logic [2:0] C_RISE = 3'h4;
	localparam logic [2:0] C_EDGE = 3'h5;
	localparam logic [1:0] TP_PRE = 2'h0;
	localparam logic [1:0] TP_CENTER = 2'h1;
	localparam logic [1:0] TP_POST = 2'h2;
	localparam logic [1:0] OP_LT = 2'h0;
	localparam logic [1:0] OP_LE = 2'h1;
	localparam logic [1:0] OP_EQ = 2'h2;
	localparam logic [1:0] OP_NE = 2'h3;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_PRE = 4'h2,
		ST_POST = 4'h4,
		ST_DONE = 4'h8
	} ect_state_t;

endpackage : ect_pkg

/* File: rtl/ect_fifo2.sv */
// Small valid/ready buffer in the debug output path.
`timescale 1ns/1ps
module ect_fifo2 #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 2
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PTW = $clog2(DEPTH);

	logic [WIDTH-1:0] slot_r [DEPTH];
	logic [PTW-1:0] wptr_r;
	logic [PTW-1:0] rptr_r;
	logic [PTW:0] cnt_r;
	logic push;
	logic pop;

	// Handshakes follow the fill level directly.
	assign in_ready = (cnt_r != DEPTH[PTW:0]);
	assign out_valid = (cnt_r != '0);
	assign out_data = slot_r[rptr_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage slots take words without reset.
	always_ff @(posedge clk) begin
		if (push) begin
			slot_r[wptr_r] <= in_data;
		end
	end

	// Pointers wrap at the depth, the count tracks the fill level.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wptr_r <= (wptr_r == PTW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
			end
			if (pop) begin
				rptr_r <= (rptr_r == PTW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
			end
			cnt_r <= cnt_r + (PTW+1)'(push) - (PTW+1)'(pop);
		end
	end

endmodule : ect_fifo2

/* File: rtl/ect_core.sv */
// Capture core: trigger logic, acquisition buffer, APB registers, debug out.
`timescale 1ns/1ps
module ect_core #(
	parameter int MEM_KIND = ect_pkg::MEM_BLOCK
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Probed design.
	input wire logic [ect_pkg::PW-1:0] probe,
	input wire logic sample_valid,
	output logic sample_ready,
	// External analyzer.
	output logic [ect_pkg::PW-1:0] dbg_data,
	output logic dbg_trig,
	output logic dbg_valid,
	input wire logic dbg_ready,
	output logic trig_out,
	output logic capture_done
);
	ect_pkg::ect_state_t state_r;
	logic seg_r, cont_r, adv_r, dbg_on_r, wrapped_r, trig_seen_r, trig_out_r;
	logic [1:0] tpos_r;
	logic [2:0] segl_r;
	logic [ect_pkg::CW-1:0] depth_r, post_cnt_r, need, post_len, cnt_now;
	logic [ect_pkg::CW-1:0] seg_len;
	logic [ect_pkg::PW-1:0] trg_en_r, str_en_r, dbg_en_r, prev_r;
	logic [23:0] cond_r;
	logic [7:0] buspat_r;
	logic [15:0] adv_cfg_r;
	logic [ect_pkg::AW-1:0] wptr_r, trig_addr_r, rd_addr_r, wptr_inc;
	logic [7:0] seg_idx_r;
	logic [ect_pkg::PW-1:0] rd_q;
	logic pready_r, wr_go, arm, stop, mapped, hit_basic, hit_adv, trig_hit;
	logic mem_we, seg_last;
	logic [31:0] prdata_r, rd_val;
	logic [7:0] a_op, b_op;
	logic cmp_ok;

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------

	// One wait state: data is loaded in the first access cycle.
	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pready_r & ~mapped;
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= ect_pkg::A_RDDATA);
	assign wr_go = psel & penable & pready_r & pwrite & mapped;
	assign arm = wr_go && paddr == ect_pkg::A_CTRL && pwdata[ect_pkg::B_ARM];
	assign stop = wr_go && paddr == ect_pkg::A_CTRL && pwdata[ect_pkg::B_STOP];

	// Access phase handshake and read data capture.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= psel & penable & ~pready_r;
			if (psel & penable & ~pready_r) begin
				prdata_r <= (mapped & ~pwrite) ? rd_val : 32'h0000_0000;
			end
		end
	end

	// Read multiplexer; unused upper bits read as zero.
	always_comb begin
		rd_val = 32'h0000_0000;
		case (paddr)
			ect_pkg::A_CTRL: rd_val = {20'h0, dbg_on_r, segl_r, 1'b0, tpos_r,
				adv_r, cont_r, seg_r, 2'h0};
			ect_pkg::A_DEPTH: rd_val = {14'h0, depth_r};
			ect_pkg::A_TRGEN: rd_val = {16'h0, trg_en_r};
			ect_pkg::A_STREN: rd_val = {16'h0, str_en_r};
			ect_pkg::A_DBGEN: rd_val = {16'h0, dbg_en_r};
			ect_pkg::A_COND: rd_val = {8'h0, cond_r};
			ect_pkg::A_BUSPAT: rd_val = {24'h0, buspat_r};
			ect_pkg::A_ADV: rd_val = {16'h0, adv_cfg_r};
			ect_pkg::A_STATUS: rd_val = {16'h0, seg_idx_r, 2'h0, wrapped_r,
				trig_seen_r, state_r};
			ect_pkg::A_TRIGADDR: rd_val = {15'h0, trig_addr_r};
			ect_pkg::A_RDADDR: rd_val = {15'h0, rd_addr_r};
			ect_pkg::A_RDDATA: rd_val = {16'h0, rd_q};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Configuration registers; arm and stop are self-clearing commands.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{seg_r, cont_r, adv_r, dbg_on_r} <= 4'h0;
			tpos_r <= ect_pkg::TP_CENTER;
			segl_r <= 3'h0;
			depth_r <= ect_pkg::DEPTH_RST;
			trg_en_r <= ect_pkg::EN_RST;
			str_en_r <= ect_pkg::EN_RST;
			dbg_en_r <= 16'h0000;
			cond_r <= 24'h00_0000;
			buspat_r <= 8'h00;
			adv_cfg_r <= 16'h0000;
			rd_addr_r <= '0;
		end else if (wr_go) begin
			case (paddr)
				ect_pkg::A_CTRL: begin
					seg_r <= pwdata[ect_pkg::B_SEG];
					cont_r <= pwdata[ect_pkg::B_CONT];
					adv_r <= pwdata[ect_pkg::B_ADV];
					tpos_r <= pwdata[ect_pkg::B_TPOS +: 2];
					segl_r <= pwdata[ect_pkg::B_SEGL +: 3];
					dbg_on_r <= pwdata[ect_pkg::B_DBG];
				end
				ect_pkg::A_DEPTH: depth_r <= (pwdata[17:0] > ect_pkg::DEPTH_MAX) ?
					ect_pkg::DEPTH_MAX : pwdata[17:0];
				ect_pkg::A_TRGEN: trg_en_r <= pwdata[15:0];
				ect_pkg::A_STREN: str_en_r <= pwdata[15:0];
				ect_pkg::A_DBGEN: dbg_en_r <= pwdata[15:0];
				ect_pkg::A_COND: cond_r <= pwdata[23:0];
				ect_pkg::A_BUSPAT: buspat_r <= pwdata[7:0];
				ect_pkg::A_ADV: adv_cfg_r <= pwdata[15:0];
				ect_pkg::A_RDADDR: rd_addr_r <= pwdata[16:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Trigger evaluation
	// ------------------------------------------------------------

	// One single-bit condition against the current and previous sample.
	function automatic logic bit_ok(input logic [2:0] c, input logic cur,
		input logic old);
		case (c)
			ect_pkg::C_DC: bit_ok = 1'b1;
			ect_pkg::C_LOW: bit_ok = ~cur;
			ect_pkg::C_HIGH: bit_ok = cur;
			ect_pkg::C_FALL: bit_ok = old & ~cur;
			ect_pkg::C_RISE: bit_ok = ~old & cur;
			ect_pkg::C_EDGE: bit_ok = old ^ cur;
			default: bit_ok = 1'b1;
		endcase
	endfunction : bit_ok

	// Basic trigger: AND over enabled bit conditions and the bus pattern.
	always_comb begin
		hit_basic = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (trg_en_r[i] && !bit_ok(cond_r[3*i +: 3], probe[i], prev_r[i])) begin
				hit_basic = 1'b0;
			end
		end
		if (((probe[15:8] ^ buspat_r) & trg_en_r[15:8]) != 8'h00) begin
			hit_basic = 1'b0;
		end
	end

	// Advanced trigger: bus compared with a constant or the low byte.
	assign a_op = probe[15:8] & trg_en_r[15:8];
	assign b_op = adv_cfg_r[ect_pkg::B_ADV_SRC] ? (probe[7:0] & trg_en_r[7:0]) :
		adv_cfg_r[ect_pkg::B_ADV_K +: 8];
	always_comb begin
		case (adv_cfg_r[1:0])
			ect_pkg::OP_LT: cmp_ok = a_op < b_op;
			ect_pkg::OP_LE: cmp_ok = a_op <= b_op;
			ect_pkg::OP_EQ: cmp_ok = a_op == b_op;
			ect_pkg::OP_NE: cmp_ok = a_op != b_op;
			default: cmp_ok = 1'b0;
		endcase
	end
	assign hit_adv = cmp_ok & (hit_basic | ~adv_cfg_r[ect_pkg::B_ADV_AND]);
	assign trig_hit = sample_valid & ~cont_r & (adv_r ? hit_adv : hit_basic);

	// Previous sample for edge conditions.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev_r <= 16'h0000;
		end else if (sample_valid) begin
			prev_r <= probe;
		end
	end

	// ------------------------------------------------------------
	// Acquisition control
	// ------------------------------------------------------------

	// Post-trigger length from the trigger position, never below one.
	always_comb begin
		case (tpos_r)
			ect_pkg::TP_PRE: post_len = depth_r - (depth_r >> 3);
			ect_pkg::TP_POST: post_len = depth_r >> 3;
			default: post_len = depth_r >> 1;
		endcase
		if (post_len == '0) begin
			post_len = 18'h00001;
		end
	end
	assign seg_len = depth_r >> segl_r;
	assign need = (seg_r || depth_r == '0) ? seg_len : post_len;
	assign cnt_now = (state_r == ect_pkg::ST_PRE) ? 18'h00001 :
		post_cnt_r + 18'h00001;
	assign seg_last = (seg_idx_r == 8'(({1'b0, 7'h01} << segl_r) - 8'h01));
	assign wptr_inc = (wptr_r == 17'(depth_r - 18'h00001)) ? '0 : wptr_r + 1'b1;
	assign mem_we = sample_valid & (state_r == ect_pkg::ST_POST |
		(state_r == ect_pkg::ST_PRE & (~seg_r | trig_hit)));

	// Capture sequence, advanced by each valid sample.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ect_pkg::ST_IDLE;
			wptr_r <= '0;
			post_cnt_r <= '0;
			seg_idx_r <= 8'h00;
			trig_addr_r <= '0;
			{wrapped_r, trig_seen_r, trig_out_r} <= 3'h0;
		end else begin
			trig_out_r <= 1'b0;
			if (arm) begin
				wptr_r <= '0;
				seg_idx_r <= 8'h00;
				{wrapped_r, trig_seen_r} <= 2'h0;
				state_r <= (need == '0) ? ect_pkg::ST_DONE : ect_pkg::ST_PRE;
			end else if (stop && state_r != ect_pkg::ST_IDLE) begin
				state_r <= ect_pkg::ST_DONE;
			end else begin
				if (mem_we) begin
					wptr_r <= wptr_inc;
					if (wptr_inc == '0) begin
						wrapped_r <= 1'b1;
					end
				end
				case (state_r)
					ect_pkg::ST_IDLE: ;
					ect_pkg::ST_PRE: if (trig_hit) begin
						trig_out_r <= 1'b1;
						trig_seen_r <= 1'b1;
						trig_addr_r <= wptr_r;
						post_cnt_r <= cnt_now;
						state_r <= ect_pkg::ST_POST;
					end
					ect_pkg::ST_POST: if (sample_valid) begin
						post_cnt_r <= cnt_now;
					end
					ect_pkg::ST_DONE: ;
					default: state_r <= ect_pkg::ST_IDLE;
				endcase
				if (mem_we && state_r != ect_pkg::ST_IDLE && cnt_now == need &&
					(state_r == ect_pkg::ST_POST || trig_hit)) begin
					if (seg_r && !seg_last) begin
						seg_idx_r <= seg_idx_r + 8'h01;
						state_r <= ect_pkg::ST_PRE;
					end else begin
						state_r <= ect_pkg::ST_DONE;
					end
				end
			end
		end
	end
	assign trig_out = trig_out_r;
	assign capture_done = (state_r == ect_pkg::ST_DONE);

	// ------------------------------------------------------------
	// Acquisition memory
	// ------------------------------------------------------------
	logic [ect_pkg::PW-1:0] mem [ect_pkg::MEM_WORDS];

	// Only bits with storage enabled are written.
	always_ff @(posedge clk) begin
		if (mem_we) begin
			for (int i = 0; i < ect_pkg::PW; i++) begin
				if (str_en_r[i]) begin
					mem[wptr_r][i] <= probe[i];
				end
			end
		end
	end

	// Read port style picks the memory resource the buffer maps to.
	generate
		if (MEM_KIND == ect_pkg::MEM_LUT) begin : g_lut
			assign rd_q = mem[rd_addr_r];
		end else begin : g_block
			logic [ect_pkg::PW-1:0] rd_q_r;
			always_ff @(posedge clk) begin
				rd_q_r <= mem[rd_addr_r];
			end
			assign rd_q = rd_q_r;
		end
	endgenerate

	// ------------------------------------------------------------
	// Debug output path
	// ------------------------------------------------------------
	logic dbg_in_ready;
	logic [ect_pkg::PW:0] dbg_word;

	// Masked probes plus trigger flag go to the external analyzer.
	ect_fifo2 #(.WIDTH(ect_pkg::PW + 1), .DEPTH(2)) u_dbg_buf (
		.clk(clk),
		.resetn(resetn),
		.in_valid(sample_valid & dbg_on_r),
		.in_ready(dbg_in_ready),
		.in_data({trig_hit, probe & dbg_en_r}),
		.out_valid(dbg_valid),
		.out_ready(dbg_ready),
		.out_data(dbg_word)
	);
	assign sample_ready = dbg_in_ready | ~dbg_on_r;
	assign dbg_data = dbg_word[ect_pkg::PW-1:0];
	assign dbg_trig = dbg_word[ect_pkg::PW];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_done_frozen: assert property (
		capture_done && !arm |=> !mem_we)
		else $error("buffer written after completion");
	chk_zero_depth: assert property (
		arm && depth_r == '0 |=> capture_done)
		else $error("zero depth did not finish");
	chk_circ_wrap: assert property (
		mem_we && !arm && !stop && wptr_r == 17'(depth_r - 18'h00001)
		|=> wptr_r == '0)
		else $error("write pointer did not wrap");
	chk_cont_no_trig: assert property (
		cont_r && state_r == ect_pkg::ST_PRE |-> !trig_out_r ##1 !trig_out_r)
		else $error("trigger seen in continuous mode");
	chk_trig_pulse: assert property (
		state_r == ect_pkg::ST_PRE && trig_hit && !arm && !stop &&
		!(seg_r && need == 18'h00001) |=> trig_out ##1 !trig_out)
		else $error("trigger output not a single pulse");
	chk_post_bound: assert property (
		state_r == ect_pkg::ST_POST |-> post_cnt_r < need)
		else $error("post-trigger count overran");
	chk_dbg_mask: assert property (
		dbg_valid && !$past(dbg_valid, 1) |->
		(dbg_data & ~$past(dbg_en_r, 1)) == '0)
		else $error("disabled probe reached debug port");
	chk_empty_and: assert property (
		!adv_r && !cont_r && trg_en_r == '0 && sample_valid |-> trig_hit)
		else $error("empty condition set failed to trigger");
	chk_seg_wait: assert property (
		seg_r && state_r == ect_pkg::ST_PRE && !trig_hit |-> !mem_we)
		else $error("segment written without trigger");

	cov_circ_done: cover property (
		!seg_r && state_r == ect_pkg::ST_POST ##1 capture_done);
	cov_seg_next: cover property (
		seg_r && state_r == ect_pkg::ST_POST ##1 state_r == ect_pkg::ST_PRE);
	cov_cont_stop: cover property (cont_r && stop ##1 capture_done);
	cov_adv_hit: cover property (adv_r && trig_hit);

endmodule : ect_core

/* File: bench/ect_sink_model.sv */
// External analyzer model that drains the debug port of the capture core.
`timescale 1ns/1ps
module ect_sink_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Debug port from the core.
	input wire logic [ect_pkg::PW-1:0] dbg_data,
	input wire logic dbg_trig,
	input wire logic dbg_valid,
	output logic dbg_ready,
	// Pace control from the bench.
	input wire logic slow
);
	logic [16:0] got [$];
	logic [2:0] cnt_r;

	// Ready is high each cycle, or one cycle in four when slow, so the
	// two-entry buffer in the core fills and back-pressure is exercised.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 3'h0;
			dbg_ready <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
			dbg_ready <= !slow || (cnt_r[1:0] == 2'h3);
		end
	end

	// Keeps every accepted word together with its trigger flag.
	always @(posedge clk) begin
		if (resetn && dbg_valid && dbg_ready) begin
			got.push_back({dbg_trig, dbg_data});
		end
	end
endmodule : ect_sink_model

/* File: bench/testbench.sv */
// Self-checking bench of the capture core against a behavioural model.
`timescale 1ns/1ps
`define chk(g, x, m) \
	begin \
		check_count++; \
		if ((g) !== (x)) begin \
			bad_count++; \
			$display("BAD %0t %s got %0h exp %0h", $time, m, g, x); \
		end \
	end
module testbench;
	localparam int DEP = 8;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, sample_ready, dbg_trig, dbg_valid, dbg_ready;
	logic trig_out, capture_done, sample_valid = 1'b0;
	logic [15:0] probe = 16'h0, dbg_data, st = 16'h002f, p, m_str, m_dben;
	logic [15:0] mem [DEP];
	logic [16:0] exp_q [$];
	logic [2:0] m_code;
	logic [1:0] m_op;
	logic [7:0] m_k;
	logic m_prev = 1'b0, m_dbg = 1'b0, exp_to = 1'b0;
	logic m_adv, m_cont, m_seg, m_trg, hit, tn;
	int m_st = 0, m_wp, m_cnt, m_len, m_ta;
	int bad_count = 0;
	int check_count = 0;

	ect_core #(.MEM_KIND(ect_pkg::MEM_BLOCK)) uut (.clk, .resetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.probe, .sample_valid, .sample_ready, .dbg_data, .dbg_trig,
		.dbg_valid, .dbg_ready, .trig_out, .capture_done);
	ect_sink_model sink (.clk, .resetn, .dbg_data, .dbg_trig, .dbg_valid,
		.dbg_ready, .slow);

	// Free-running 25 MHz clock.
	initial begin
		forever #20 clk = ~clk;
	end

	// Pseudo-random source for probe values and sample gaps.
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Basic per-bit condition; edges compare with the previous sample.
	function automatic logic cond_ok(input logic [2:0] c, input logic v, q);
		case (c)
			ect_pkg::C_LOW: return !v;
			ect_pkg::C_HIGH: return v;
			ect_pkg::C_FALL: return q && !v;
			ect_pkg::C_RISE: return !q && v;
			ect_pkg::C_EDGE: return q != v;
			default: return 1'b1;
		endcase
	endfunction : cond_ok

	// Advanced comparison of the probed bus with a constant.
	function automatic logic adv_ok(input logic [1:0] o, input logic [7:0] a, b);
		case (o)
			ect_pkg::OP_LT: return a < b;
			ect_pkg::OP_LE: return a <= b;
			ect_pkg::OP_EQ: return a == b;
			default: return a != b;
		endcase
	endfunction : adv_ok

	// Writes the enabled bits of the current sample into the model buffer.
	task automatic store(input int a);
		mem[a] = (mem[a] & ~m_str) | (p & m_str);
	endtask : store

	// Reference model: steps once for every sample the core takes.
	always @(posedge clk) begin
		if (resetn) begin
			`chk(trig_out, exp_to, "trigger out")
			tn = 1'b0;
			if (sample_valid) begin
				p = probe;
				hit = m_adv ? adv_ok(m_op, p[15:8], m_k) :
					cond_ok(m_code, p[0], m_prev) &&
					(m_code != ect_pkg::C_DC || p[9:8] == 2'h0);
				if (m_st == 1 && m_seg) begin
					if (m_cnt == 0 && hit) begin
						m_cnt = m_len;
						tn = 1'b1;
					end
					if (m_cnt != 0) begin
						store(m_wp);
						m_wp++;
						m_cnt--;
						if (m_wp == DEP)
							m_st = 2;
					end
				end else if (m_st == 1) begin
					store(m_wp);
					if (!m_trg && !m_cont && hit) begin
						m_trg = 1'b1;
						m_ta = m_wp;
						m_cnt = m_len;
						tn = 1'b1;
					end
					m_wp = (m_wp + 1) % DEP;
					m_cnt = m_trg ? m_cnt - 1 : m_cnt;
					if (m_trg && m_cnt == 0)
						m_st = 2;
				end
				if (m_dbg && sample_ready)
					exp_q.push_back({hit && !m_cont, p & m_dben});
				m_prev = p[0];
			end
			exp_to = tn;
		end
	end

	// Ends the run with the counts and the verdict.
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	// One APB transfer; entered and left just after a rising edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			bad_count++;
			print_verdict();
		end
		@(posedge clk);
	endtask : apb

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wreg

	task automatic rreg(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask : rreg

	// Drives samples with gaps; bit 0 is held at lvl for the first 14.
	task automatic feed(input logic lvl);
		for (int i = 0; i < 48; i++) begin
			st = lfsr(st);
			probe <= {6'h0, st[9:8], st[7:1], (i < 14) ? lvl : st[0]};
			sample_valid <= st[5] | st[11];
			@(posedge clk);
		end
		sample_valid <= 1'b0;
		@(posedge clk);
	endtask : feed

	// Configures, arms and runs one capture, then checks buffer and port.
	task automatic run(input logic [31:0] ctrl, input logic [2:0] code,
		input logic lvl, input logic [15:0] str, input logic [31:0] adv);
		logic [31:0] r, c;
		logic [16:0] g, x;
		c = ctrl | (32'h1 << ect_pkg::B_DBG);
		slow <= !slow;
		wreg(ect_pkg::A_COND, {26'h0, ect_pkg::C_HIGH, code});
		wreg(ect_pkg::A_TRGEN, c[ect_pkg::B_ADV] ? 32'hffff :
			(code == ect_pkg::C_DC) ? 32'h03fd : 32'h00fd);
		wreg(ect_pkg::A_STREN, {16'h0, str});
		wreg(ect_pkg::A_ADV, adv);
		m_code = code;
		m_str = str;
		m_adv = c[ect_pkg::B_ADV];
		m_op = adv[1:0];
		m_k = adv[15:8];
		m_cont = c[ect_pkg::B_CONT];
		m_seg = c[ect_pkg::B_SEG];
		m_len = (c[6:5] == ect_pkg::TP_PRE) ? DEP - DEP / 8 :
			(c[6:5] == ect_pkg::TP_CENTER) ? DEP / 2 : DEP / 8;
		m_len = m_seg ? DEP >> c[10:8] : m_len;
		m_wp = 0;
		m_cnt = 0;
		m_trg = 1'b0;
		m_dbg = 1'b1;
		m_st = 1;
		wreg(ect_pkg::A_CTRL, c | 32'h1);
		feed(lvl);
		if (m_cont) begin
			wreg(ect_pkg::A_CTRL, c | 32'h2);
			m_st = 2;
		end
		rreg(ect_pkg::A_STATUS, r);
		`chk({capture_done, r[3:0]}, 5'h18, "done state")
		if (!m_seg && !m_cont) begin
			rreg(ect_pkg::A_TRIGADDR, r);
			`chk(r, 32'(m_ta), "trigger address")
		end
		for (int a = 0; a < DEP; a++) begin
			wreg(ect_pkg::A_RDADDR, 32'(a));
			rreg(ect_pkg::A_RDDATA, r);
			`chk(r, {16'h0, mem[a]}, "buffer word")
		end
		`chk(sink.got.size(), exp_q.size(), "debug words")
		while (exp_q.size() > 0 && sink.got.size() > 0) begin
			g = sink.got.pop_front();
			x = exp_q.pop_front();
			`chk(g, x, "debug word")
		end
		$display("test done ctrl %h code %0d", ctrl, code);
	endtask : run

	localparam logic [7:0] RA [10] = '{ect_pkg::A_CTRL, ect_pkg::A_DEPTH,
		ect_pkg::A_TRGEN, ect_pkg::A_STREN, ect_pkg::A_DBGEN, ect_pkg::A_COND,
		ect_pkg::A_BUSPAT, ect_pkg::A_ADV, ect_pkg::A_STATUS, ect_pkg::A_RDADDR};
	localparam logic [31:0] RV [10] = '{32'h20, 32'h400, 32'hffff, 32'hffff,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};

	// Main sequence.
	initial begin
		logic [31:0] r;
		logic e;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		foreach (RA[i]) begin
			rreg(RA[i], r);
			`chk(r, RV[i], "reset value")
		end
		apb(1'b1, 8'h30, 32'h5, r, e);
		`chk({e, r}, 33'h100000000, "unmapped")
		wreg(ect_pkg::A_DEPTH, 32'h3ffff);
		rreg(ect_pkg::A_DEPTH, r);
		`chk(r, {14'h0, ect_pkg::DEPTH_MAX}, "depth clamp")
		wreg(ect_pkg::A_DEPTH, 32'h0);
		wreg(ect_pkg::A_CTRL, 32'h1);
		rreg(ect_pkg::A_STATUS, r);
		`chk(r[3:0], 4'h8, "zero depth")
		wreg(ect_pkg::A_DEPTH, DEP);
		m_dben = 16'h0f0f;
		wreg(ect_pkg::A_DBGEN, {16'h0, m_dben});
		for (int t = 0; t < 3; t++)
			run(t << ect_pkg::B_TPOS, ect_pkg::C_RISE, 1'b0, 16'hffff, 0);
		for (int c = 0; c < 6; c++)
			run(32'h20, 3'(c), c == 1 || c == 3, 16'hfffe, 0);
		run(32'h28, ect_pkg::C_RISE, 1'b0, 16'hffff, 0);
		run(32'h104, ect_pkg::C_RISE, 1'b0, 16'hffff, 0);
		for (int o = 0; o < 4; o++)
			run(32'h10, ect_pkg::C_DC, 1'b0, 16'hffff, 32'h200 | o);
		print_verdict();
	end
endmodule : testbench
